// file: hdl/asp_top.sv
// Asynchronous serial port without FIFO, with loopback and baud generator
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Transmit and receive run at once, independently, from one shared tick.
// - The receiver retimes itself on each character's start edge.
// - The receiver samples sixteen ticks per bit period.
// - Software picks seven or eight data bits.
// - Software picks one or two stop bits.
// - Software picks even, odd or no parity; transmit makes it, receive checks.
// - Receive flags parity, framing and overrun errors.
// - Loopback routes transmit output to receive input internally.
// - In loopback, software can force parity, framing and overrun errors.
// - An 8-bit programmable counter divides the clock to make the tick.
// - Baud timing runs from the peripheral clock, not the bus clock.
// - The baud clock stops while the processor is halted.
// - All port logic runs in the peripheral clock domain.
module asp_top
    import asp_pkg::*;
(
    // Peripheral clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Power state
    input wire logic i_halt,
    // Serial line
    input wire logic i_rxd,
    output logic o_txd
);
    // Registers
    logic [4:0] ctrl;
    logic [7:0] baud_div;
    logic [2:0] force_err;
    logic tick;

    wire logic len8 = ctrl[ASP_CTRL_LEN8];
    wire logic stop2 = ctrl[ASP_CTRL_STOP2];
    wire logic par_en = ctrl[ASP_CTRL_PAREN];
    wire logic par_odd = ctrl[ASP_CTRL_PARODD];
    wire logic loop_on = ctrl[ASP_CTRL_LOOP];

    // Pin synchroniser; the first stage feeds only the second
    logic rxd_s1;
    logic rxd_s2;
    logic halt_s1;
    logic halt_s2;
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
        end
        else
        begin
            rxd_s1 <= i_rxd;
            rxd_s2 <= rxd_s1;
            halt_s1 <= i_halt;
            halt_s2 <= halt_s1;
        end
    end

    // Baud generator on the peripheral clock, not the bus clock
    asp_baud_gen #(.DIV_W(8)) u_baud (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_div(baud_div),
        .i_halt(halt_s2),
        .o_tick(tick)
    );

    // Register decode
    wire logic wr_data = i_wr && (i_addr == ASP_REG_DATA);
    wire logic wr_ctrl = i_wr && (i_addr == ASP_REG_CTRL);
    wire logic wr_baud = i_wr && (i_addr == ASP_REG_BAUD);
    wire logic wr_force = i_wr && (i_addr == ASP_REG_FORCE);
    wire logic wr_stat = i_wr && (i_addr == ASP_REG_STAT);
    wire logic rd_data = i_rd && (i_addr == ASP_REG_DATA);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ctrl <= ASP_CTRL_RST;
            baud_div <= ASP_BAUD_RST;
            force_err <= 3'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= i_wdata[4:0];
            if (wr_baud)
                baud_div <= i_wdata;
            if (wr_force)
                force_err <= i_wdata[2:0];
        end
    end

    // Force bits only act in loopback
    wire logic f_par = loop_on && force_err[ASP_FORCE_PAR];
    wire logic f_frm = loop_on && force_err[ASP_FORCE_FRM];
    wire logic f_ovr = loop_on && force_err[ASP_FORCE_OVR];

    // ---------------- Transmitter ----------------
    asp_state_e tx_state;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] tx_shift;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic tx_par;
    logic tx_line;
    wire logic tx_bit_end = tick && (tx_tick == ASP_LAST_TICK);
    wire logic [2:0] last_data = len8 ? 3'h7 : 3'h6;
    // Forced parity error inverts the sent parity bit
    wire logic tx_par_bit = tx_par ^ par_odd ^ f_par;
    wire logic tx_busy = (tx_state != ASP_IDLE);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            tx_state <= ASP_IDLE;
            tx_hold <= 8'h00;
            tx_full <= 1'b0;
            tx_shift <= 8'h00;
            tx_tick <= 4'h0;
            tx_bit <= 3'h0;
            tx_par <= 1'b0;
            tx_line <= 1'b1;
        end
        else
        begin
            if (wr_data)
            begin
                tx_hold <= i_wdata;
                tx_full <= 1'b1;
            end
            if (tick)
                tx_tick <= tx_tick + 4'h1;
            case (tx_state)
                ASP_IDLE:
                begin
                    tx_line <= 1'b1;
                    if (tx_full && tick && !wr_data)
                    begin
                        tx_shift <= tx_hold;
                        tx_full <= 1'b0;
                        tx_par <= 1'b0;
                        tx_tick <= 4'h0;
                        tx_line <= 1'b0;
                        tx_state <= ASP_START;
                    end
                end
                ASP_START:
                begin
                    if (tx_bit_end)
                    begin
                        tx_line <= tx_shift[0];
                        tx_par <= tx_shift[0];
                        tx_bit <= 3'h0;
                        tx_state <= ASP_DATA;
                    end
                end
                ASP_DATA:
                begin
                    if (tx_bit_end)
                    begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == last_data)
                        begin
                            tx_line <= par_en ? tx_par_bit : f_frm ? 1'b0
                                : 1'b1;
                            tx_state <= par_en ? ASP_PAR : ASP_STOP;
                            tx_bit <= 3'h0;
                        end
                        else
                        begin
                            tx_line <= tx_shift[1];
                            tx_par <= tx_par ^ tx_shift[1];
                        end
                    end
                end
                ASP_PAR:
                begin
                    if (tx_bit_end)
                    begin
                        // Forced framing error sends a low stop bit
                        tx_line <= ~f_frm;
                        tx_state <= ASP_STOP;
                    end
                end
                ASP_STOP:
                begin
                    if (tx_bit_end)
                    begin
                        tx_line <= 1'b1;
                        if (stop2 && tx_bit == 3'h0)
                            tx_bit <= 3'h1;
                        else
                            tx_state <= ASP_IDLE;
                    end
                end
                default:
                    tx_state <= ASP_IDLE;
            endcase
        end
    end

    // ---------------- Receiver ----------------
    // Loopback keeps the pin idle and feeds the receiver internally
    wire logic rx_in = loop_on ? tx_line : rxd_s2;

    asp_state_e rx_state;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic rx_par;
    logic rx_full;
    logic perr;
    logic ferr;
    logic oerr;
    // Edge, not level: a low stop bit must not restart the receiver
    logic rx_prev;
    wire logic rx_mid = tick && (rx_tick == ASP_MID_TICK);
    wire logic rx_done = rx_mid && (rx_state == ASP_STOP);
    wire logic par_bad = par_en && ((rx_par ^ par_odd) != 1'b0);
    // Store character, shifting 7-bit data into place
    wire logic [7:0] rx_word = len8 ? rx_shift : {1'b0, rx_shift[7:1]};
    wire logic ovr_hit = rx_done && (rx_full || f_ovr);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rx_state <= ASP_IDLE;
            rx_shift <= 8'h00;
            rx_tick <= 4'h0;
            rx_bit <= 3'h0;
            rx_par <= 1'b0;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_prev <= rx_in;
            if (tick)
                rx_tick <= rx_tick + 4'h1;
            case (rx_state)
                ASP_IDLE:
                begin
                    if (rx_prev && !rx_in)
                    begin
                        rx_tick <= 4'h0;
                        rx_state <= ASP_START;
                    end
                end
                ASP_START:
                begin
                    if (rx_mid)
                    begin
                        // Glitch shorter than half a bit is dropped
                        rx_state <= rx_in ? ASP_IDLE : ASP_DATA;
                        rx_bit <= 3'h0;
                        rx_par <= 1'b0;
                    end
                end
                ASP_DATA:
                begin
                    if (rx_mid)
                    begin
                        rx_shift <= {rx_in, rx_shift[7:1]};
                        rx_par <= rx_par ^ rx_in;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == last_data)
                            rx_state <= par_en ? ASP_PAR : ASP_STOP;
                    end
                end
                ASP_PAR:
                begin
                    if (rx_mid)
                    begin
                        rx_par <= rx_par ^ rx_in;
                        rx_state <= ASP_STOP;
                    end
                end
                ASP_STOP:
                begin
                    // Only the first stop bit is checked, for early retiming
                    if (rx_mid)
                        rx_state <= ASP_IDLE;
                end
                default:
                    rx_state <= ASP_IDLE;
            endcase
        end
    end

    // Receive holding register and sticky errors; set beats clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rx_data <= 8'h00;
            rx_full <= 1'b0;
            perr <= 1'b0;
            ferr <= 1'b0;
            oerr <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rx_data <= rx_word;
            rx_full <= rx_done || (rx_full && !rd_data);
            perr <= (rx_done && par_bad)
                || (perr && !(wr_stat && i_wdata[ASP_STAT_PERR]));
            ferr <= (rx_done && !rx_in)
                || (ferr && !(wr_stat && i_wdata[ASP_STAT_FERR]));
            oerr <= ovr_hit
                || (oerr && !(wr_stat && i_wdata[ASP_STAT_OERR]));
        end
    end

    // Read path
    wire logic [7:0] stat_word = {2'b00, tx_busy, oerr, ferr, perr,
        !tx_full, rx_full};
    logic [7:0] rd_mux;
    always_comb
    begin
        if (i_addr == ASP_REG_DATA)
            rd_mux = rx_data;
        else if (i_addr == ASP_REG_CTRL)
            rd_mux = {3'b000, ctrl};
        else if (i_addr == ASP_REG_STAT)
            rd_mux = stat_word;
        else if (i_addr == ASP_REG_BAUD)
            rd_mux = baud_div;
        else if (i_addr == ASP_REG_FORCE)
            rd_mux = {5'b00000, force_err};
        else
            rd_mux = 8'h00;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= 8'h00;
            o_txd <= 1'b1;
        end
        else
        begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
            // Line idles high during loopback
            o_txd <= loop_on ? 1'b1 : tx_line;
        end
    end
endmodule

// file: hdl/asp_pkg.sv
// Constants and types for the asynchronous serial port
package asp_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ASP_REG_DATA = 3'h0;
    localparam logic [2:0] ASP_REG_CTRL = 3'h1;
    localparam logic [2:0] ASP_REG_STAT = 3'h2;
    localparam logic [2:0] ASP_REG_BAUD = 3'h3;
    localparam logic [2:0] ASP_REG_FORCE = 3'h4;
    // Control fields
    localparam int ASP_CTRL_LEN8 = 0;
    localparam int ASP_CTRL_STOP2 = 1;
    localparam int ASP_CTRL_PAREN = 2;
    localparam int ASP_CTRL_PARODD = 3;
    localparam int ASP_CTRL_LOOP = 4;
    // Status fields
    localparam int ASP_STAT_RXRDY = 0;
    localparam int ASP_STAT_TXRDY = 1;
    localparam int ASP_STAT_PERR = 2;
    localparam int ASP_STAT_FERR = 3;
    localparam int ASP_STAT_OERR = 4;
    localparam int ASP_STAT_TXBUSY = 5;
    // Force fields (loopback only)
    localparam int ASP_FORCE_PAR = 0;
    localparam int ASP_FORCE_FRM = 1;
    localparam int ASP_FORCE_OVR = 2;
    // Reset values
    localparam logic [4:0] ASP_CTRL_RST = 5'h01;
    localparam logic [7:0] ASP_BAUD_RST = 8'h00;
    // Oversampling
    localparam int ASP_OVERSAMPLE = 16;
    localparam logic [3:0] ASP_MID_TICK = 4'h7;
    localparam logic [3:0] ASP_LAST_TICK = 4'hF;

    typedef enum logic [4:0] {
        ASP_IDLE = 5'b00001,
        ASP_START = 5'b00010,
        ASP_DATA = 5'b00100,
        ASP_PAR = 5'b01000,
        ASP_STOP = 5'b10000
    } asp_state_e;
endpackage

// file: hdl/asp_baud_gen.sv
// Programmable 8-bit baud divider producing the sample tick
`timescale 1ns/1ps
module asp_baud_gen
    import asp_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Control
    input wire logic [DIV_W-1:0] i_div,
    input wire logic i_halt,
    // Tick
    output logic o_tick
);
    // Elaboration-time guard on the divider width
    if (DIV_W < 1)
    begin
        $error("asp_baud_gen: DIV_W must be positive");
    end

    logic [DIV_W-1:0] count;
    wire logic at_end = (count == i_div);

    // Held still during halt so the tick phase resumes cleanly
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            count <= '0;
            o_tick <= 1'b0;
        end
        else if (i_halt)
        begin
            o_tick <= 1'b0;
        end
        else
        begin
            count <= at_end ? '0 : count + 1'b1;
            o_tick <= at_end;
        end
    end
endmodule

// file: testbench/asp_checker.sv
// Port-level assertions for the serial port
`timescale 1ns/1ps
module asp_checker
    import asp_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Power and line
    input wire logic i_halt,
    input wire logic i_rxd,
    input wire logic o_txd
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [4:0] ctrl;
    logic [7:0] baud;
    logic [15:0] low_run;
    wire wr_ctrl = i_wr && i_addr == ASP_REG_CTRL;
    wire wr_baud = i_wr && i_addr == ASP_REG_BAUD;
    wire [15:0] bit_len = {4'h0, baud, 4'h0} + 16'h0010;
    // Halt stretches a bit, so only a lower bound is safe
    always_ff @(posedge i_ref_clk)
    begin
        low_run <= o_txd ? 16'h0000 : low_run + 16'h0001;
        if (i_rst)
        begin
            ctrl <= ASP_CTRL_RST;
            baud <= ASP_BAUD_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= i_wdata[4:0];
            if (wr_baud)
                baud <= i_wdata;
        end
    end
    sequence s_halt_held;
        i_halt [*8];
    endsequence
    sequence s_rd_ctrl;
        i_rd && i_addr == ASP_REG_CTRL;
    endsequence
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    property p_reset_txd;
        $fell(i_rst) |-> o_txd;
    endproperty
    property p_bit_width;
        $rose(o_txd) |-> low_run >= bit_len;
    endproperty
    property p_loop_quiet;
        ctrl[ASP_CTRL_LOOP] && $past(ctrl[ASP_CTRL_LOOP], 2) |-> o_txd;
    endproperty
    property p_ctrl_rb;
        s_rd_ctrl |=> o_rdata == {3'h0, $past(ctrl)};
    endproperty
    property p_baud_rb;
        i_rd && i_addr == ASP_REG_BAUD |=> o_rdata == $past(baud);
    endproperty
    property p_unmapped;
        i_rd && i_addr > ASP_REG_FORCE |=> o_rdata == 8'h00;
    endproperty
    property p_len7;
        i_rd && i_addr == ASP_REG_DATA && !ctrl[ASP_CTRL_LEN8]
            |=> !o_rdata[7];
    endproperty
    property p_halt;
        s_halt_held |-> $stable(o_txd);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read slot");
    a_reset_txd: assert property (p_reset_txd)
        else $error("line not idle after reset");
    a_bit_width: assert property (p_bit_width)
        else $error("low bit shorter than sixteen ticks");
    a_loop_quiet: assert property (p_loop_quiet)
        else $error("line driven during loopback");
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback wrong");
    a_baud_rb: assert property (p_baud_rb)
        else $error("divider readback wrong");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_len7: assert property (p_len7)
        else $error("seven bit data has bit seven set");
    a_halt: assert property (p_halt)
        else $error("line moved while halted");
endmodule
bind asp_top asp_checker asp_checker_i (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt), .i_rxd(i_rxd),
    .o_txd(o_txd));

// file: testbench/asp_remote.sv
// Behavioural remote serial party on the line side
`timescale 1ns/1ps
module asp_remote
(
    // Clock and frame setup
    input wire logic i_ref_clk,
    input wire logic [15:0] i_bit_len,
    input wire logic i_len8,
    input wire logic i_par_en,
    input wire logic i_par_odd,
    // Line
    input wire logic i_line_in,
    output logic o_line,
    // Received character
    output logic [7:0] o_got,
    output logic o_got_perr,
    output logic o_got_ferr
);
    event got;
    logic [7:0] acc;
    logic p;
    int k;
    initial o_line = 1'b1;
    task automatic put(input logic b);
        @(posedge i_ref_clk);
        o_line <= b;
        repeat (i_bit_len - 1) @(posedge i_ref_clk);
    endtask
    task automatic send(input logic [7:0] d, input logic bp,
        input logic bs, input int gap);
        int n;
        repeat (gap) @(posedge i_ref_clk);
        put(1'b0);
        for (n = 0; n < (i_len8 ? 8 : 7); n++)
            put(d[n]);
        if (i_par_en)
            put(^d[6:0] ^ (i_len8 & d[7]) ^ i_par_odd ^ bp);
        put(~bs);
        put(1'b1);
    endtask
    // Samples mid-bit, timed from each start edge
    always
    begin
        @(negedge i_line_in);
        repeat (i_bit_len / 2) @(posedge i_ref_clk);
        acc = 8'h00;
        p = i_par_odd;
        for (k = 0; k < (i_len8 ? 8 : 7); k++)
        begin
            repeat (i_bit_len) @(posedge i_ref_clk);
            acc[k] = i_line_in;
            p = p ^ i_line_in;
        end
        if (i_par_en)
        begin
            repeat (i_bit_len) @(posedge i_ref_clk);
            p = p ^ i_line_in;
        end
        repeat (i_bit_len) @(posedge i_ref_clk);
        o_got_perr = i_par_en & p;
        o_got_ferr = ~i_line_in;
        o_got = acc;
        -> got;
    end
endmodule

// file: testbench/test_async_serial_port_no_fifo.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module test_async_serial_port_no_fifo
    import asp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic quiet = 1'b0;
    logic halt = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] rdata, got, ctrl, div, d, dr;
    logic txd, rxd, perr, ferr;
    logic [7:0] rd_q[$];
    logic [7:0] tx_q[$];
    int err_total = 0;
    int checks = 0;
    int i, n;
    wire [15:0] bl = {4'h0, div, 4'h0} + 16'h0010;
    always #2.5 clk = ~clk;
    asp_top asp_top_i (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_halt(halt), .i_rxd(rxd), .o_txd(txd));
    asp_remote asp_remote_i (.i_ref_clk(clk), .i_bit_len(bl),
        .i_len8(ctrl[0]), .i_par_en(ctrl[2]), .i_par_odd(ctrl[3]),
        .i_line_in(txd), .o_line(rxd), .o_got(got), .o_got_perr(perr),
        .o_got_ferr(ferr));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Polling reads bypass the expectation queue
    task automatic poll(input int b, input logic v);
        int m = 0;
        do
        begin
            @(posedge clk);
            addr <= ASP_REG_STAT;
            rd <= 1'b1;
            quiet <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            quiet <= 1'b0;
            @(negedge clk);
            m++;
        end while (rdata[b] !== v && m < 4000);
        if (m >= 4000)
        begin
            err_total++;
            $display("[ERR] %0t status wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic duplex(input logic bp, input logic bs);
        d = 8'($urandom);
        dr = 8'($urandom);
        tx_q.push_back(ctrl[0] ? d : {1'b0, d[6:0]});
        fork
            asp_remote_i.send(dr, bp, bs, $urandom % 40);
            begin
                wreg(ASP_REG_DATA, d);
                poll(ASP_STAT_RXRDY, 1'b1);
                poll(ASP_STAT_TXBUSY, 1'b0);
            end
        join
    endtask
    always @(posedge clk)
        rd_seen <= rd & ~quiet;
    always @(negedge clk)
        if (rd_seen)
            chk(rdata, rd_q.pop_front());
    always @(asp_remote_i.got)
    begin
        chk(got, tx_q.pop_front());
        chk({6'h00, ferr, perr}, 8'h00);
    end
    initial
    begin
        ctrl = 8'h01;
        div = 8'h00;
        i = $urandom(78);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rreg(ASP_REG_CTRL, 8'h01);
        rreg(ASP_REG_STAT, 8'h02);
        rreg(ASP_REG_FORCE, 8'h00);
        wreg(3'h6, 8'hFF);
        rreg(3'h6, 8'h00);
        rreg(3'h7, 8'h00);
        rreg(ASP_REG_BAUD, 8'h00);
        div = 8'($urandom % 3);
        wreg(ASP_REG_BAUD, div);
        rreg(ASP_REG_BAUD, div);
        for (i = 0; i < 16; i++)
        begin
            ctrl = 8'(i);
            wreg(ASP_REG_CTRL, ctrl);
            rreg(ASP_REG_CTRL, ctrl);
            duplex(1'b0, 1'b0);
            rreg(ASP_REG_STAT, 8'h03);
            rreg(ASP_REG_DATA, ctrl[0] ? dr : {1'b0, dr[6:0]});
            rreg(ASP_REG_STAT, 8'h02);
        end
        ctrl = 8'h05;
        wreg(ASP_REG_CTRL, ctrl);
        duplex(1'b1, 1'b0);
        rreg(ASP_REG_STAT, 8'h07);
        wreg(ASP_REG_STAT, 8'h1C);
        rreg(ASP_REG_STAT, 8'h03);
        rreg(ASP_REG_DATA, dr);
        duplex(1'b0, 1'b1);
        rreg(ASP_REG_STAT, 8'h0B);
        wreg(ASP_REG_STAT, 8'h1C);
        duplex(1'b0, 1'b0);
        rreg(ASP_REG_STAT, 8'h13);
        rreg(ASP_REG_DATA, dr);
        wreg(ASP_REG_STAT, 8'h1C);
        ctrl = 8'h15;
        wreg(ASP_REG_CTRL, ctrl);
        for (i = 0; i < 4; i++)
        begin
            wreg(ASP_REG_FORCE, 8'(i ? 1 << (i - 1) : 0));
            d = 8'($urandom);
            wreg(ASP_REG_DATA, d);
            poll(ASP_STAT_RXRDY, 1'b1);
            poll(ASP_STAT_TXBUSY, 1'b0);
            rreg(ASP_REG_STAT, 8'h03 | (i ? 8'h02 << i : 8'h00));
            rreg(ASP_REG_DATA, d);
            wreg(ASP_REG_STAT, 8'h1C);
        end
        ctrl = 8'h01;
        // Halt first, so the synchronised tick is stopped before the write
        halt <= 1'b1;
        wreg(ASP_REG_FORCE, 8'h00);
        wreg(ASP_REG_CTRL, ctrl);
        d = 8'($urandom);
        tx_q.push_back(d);
        wreg(ASP_REG_DATA, d);
        n = 0;
        repeat (200)
        begin
            @(posedge clk);
            n = n + (txd ? 0 : 1);
        end
        chk(8'(n), 8'h00);
        halt <= 1'b0;
        n = 0;
        while (tx_q.size() > 0 && n < 8000)
        begin
            @(posedge clk);
            n++;
        end
        chk(8'(tx_q.size()), 8'h00);
        report_and_stop();
    end
endmodule
